//--- srctl_cfg.svh
`ifndef SRCTL_CFG_SVH
`define SRCTL_CFG_SVH
`define SRCTL_SOFT_RESET_OFS 8'h01
`define SRCTL_SOFT_RESET_RST 8'h00
`define SRCTL_CORE_BIT 4
`define SRCTL_REG_BIT 0
`define SRCTL_RAM_DEPTH 32
`endif

//--- srctl_pkg.sv
package srctl_pkg;
  typedef logic [7:0] srctl_byte_type;
  typedef enum logic [1:0] {
    SRCTL_IDLE = 2'b00,
    SRCTL_WIPE = 2'b01
  } srctl_state_type;
endpackage

//--- srctl_ram_wipe.sv
`timescale 1ns/100ps
`include "srctl_cfg.svh"
module srctl_ram_wipe #(
  parameter int DEPTH = `SRCTL_RAM_DEPTH
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic start_in,
  output logic busy_out,
  output logic [$clog2(DEPTH)-1:0] addr_out
);
  import srctl_pkg::*;
  srctl_state_type state;
  // Walk the coefficient RAM once, one word per cycle
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state <= SRCTL_IDLE;
      addr_out <= '0;
    end else begin
      unique case (state)
        SRCTL_IDLE: begin
          addr_out <= '0;
          if (start_in) begin
            state <= SRCTL_WIPE;
          end
        end
        SRCTL_WIPE: begin
          if (addr_out == ($clog2(DEPTH))'(DEPTH - 1)) begin
            state <= SRCTL_IDLE;
            addr_out <= '0;
          end else begin
            addr_out <= addr_out + 1'b1;
          end
        end
        default: state <= SRCTL_IDLE;
      endcase
    end
  end
  assign busy_out = (state == SRCTL_WIPE);
endmodule

//--- srctl_top.sv
// Function
// - Bit 4 resets whole digital path
// - Core reset makes processor wipe RAM
// - Bit 0 restores control registers
// - Register reset leaves RAM untouched
// - Register at 1h reads zero, reserved
`timescale 1ns/100ps
`include "srctl_cfg.svh"
module srctl_top #(
  parameter int DEPTH = `SRCTL_RAM_DEPTH
) (
  input wire logic clk_in,
  input wire logic arst_n_in,
  input wire logic wr_en_in,
  input wire logic rd_en_in,
  input wire srctl_pkg::srctl_byte_type addr_in,
  input wire srctl_pkg::srctl_byte_type wdata_in,
  output srctl_pkg::srctl_byte_type rdata_out,
  output logic core_reset_out,
  output logic regs_reset_out,
  output logic ram_wipe_out,
  output logic [$clog2(DEPTH)-1:0] ram_addr_out
);
  import srctl_pkg::*;
  logic rst_s1;
  logic rst_n;
  logic hit;
  logic wipe_busy;
  logic [$clog2(DEPTH)-1:0] wipe_addr;
  logic wipe_start;
  logic core_req;
  logic regs_req;
  // Check helpers: wipe address width, last word, sweep length
  localparam int AW = $clog2(DEPTH);
  localparam int WIPE_SPAN = DEPTH;
  localparam logic [AW-1:0] LAST_ADDR = AW'(DEPTH - 1);
  localparam logic [AW:0] RUN_FULL = (AW + 1)'(DEPTH);
  logic [AW:0] wipe_run;
  // Reset release through two flops
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rst_s1 <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_s1 <= 1'b1;
      rst_n <= rst_s1;
    end
  end
  // Reserved offsets are host's concern; only 1h decoded
  assign hit = (addr_in == `SRCTL_SOFT_RESET_OFS);
  // Write strobes that land on the soft-reset register
  assign core_req = wr_en_in & hit & wdata_in[`SRCTL_CORE_BIT];
  // Core reset also covers registers, so it raises both
  assign regs_req = wr_en_in & hit &
    (wdata_in[`SRCTL_REG_BIT] | wdata_in[`SRCTL_CORE_BIT]);
  // Action bits are one-cycle pulses, never stored, so they read back zero
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      core_reset_out <= 1'b0;
      regs_reset_out <= 1'b0;
    end else begin
      core_reset_out <= core_req;
      regs_reset_out <= regs_req;
    end
  end
  // Core bit written: both pulses follow
  a_core_pulse: assert property (@(posedge clk_in) disable iff (!rst_n)
    (wr_en_in && addr_in == `SRCTL_SOFT_RESET_OFS && wdata_in[`SRCTL_CORE_BIT])
    |=> core_reset_out && regs_reset_out)
    else $error("core reset not issued");
  // Register bit alone: register pulse without core pulse
  a_reg_only: assert property (@(posedge clk_in) disable iff (!rst_n)
    (wr_en_in && hit && wdata_in[`SRCTL_REG_BIT] && !wdata_in[`SRCTL_CORE_BIT])
    |=> regs_reset_out && !core_reset_out)
    else $error("register reset wrong");
  // Register bit always gives a register pulse
  a_regs_pulse: assert property (@(posedge clk_in) disable iff (!rst_n)
    (wr_en_in && hit && wdata_in[`SRCTL_REG_BIT])
    |=> regs_reset_out)
    else $error("register reset missing");
  // Full reset never leaves the registers alone
  a_core_has_regs: assert property (@(posedge clk_in) disable iff (!rst_n)
    core_reset_out
    |-> regs_reset_out)
    else $error("core reset without register reset");
  // Core pulse only after a core write
  a_core_cause: assert property (@(posedge clk_in) disable iff (!rst_n)
    core_reset_out
    |-> $past(core_req))
    else $error("core pulse without write");
  // Register pulse only after a register or core write
  a_regs_cause: assert property (@(posedge clk_in) disable iff (!rst_n)
    regs_reset_out
    |-> $past(regs_req))
    else $error("register pulse without write");
  // Core bit clears unless written again
  a_self_clear: assert property (@(posedge clk_in) disable iff (!rst_n)
    core_reset_out
    |=> !core_reset_out || $past(wr_en_in))
    else $error("bit did not self clear");
  // Core pulse lasts one cycle per write
  a_core_single: assert property (@(posedge clk_in) disable iff (!rst_n)
    core_reset_out && !core_req
    |=> !core_reset_out)
    else $error("core pulse stretched");
  // Register pulse lasts one cycle per write
  a_regs_single: assert property (@(posedge clk_in) disable iff (!rst_n)
    regs_reset_out && !regs_req
    |=> !regs_reset_out)
    else $error("register pulse stretched");
  // Zeros in both action bits do nothing
  a_zero_write: assert property (@(posedge clk_in) disable iff (!rst_n)
    (wr_en_in && hit && !wdata_in[`SRCTL_CORE_BIT] && !wdata_in[`SRCTL_REG_BIT])
    |=> !regs_reset_out && !core_reset_out)
    else $error("zero write acted");
  // No write to the register, no action
  a_miss_idle: assert property (@(posedge clk_in) disable iff (!rst_n)
    (!wr_en_in || addr_in != `SRCTL_SOFT_RESET_OFS)
    |=> !core_reset_out && !regs_reset_out)
    else $error("action without write");
  // Wiper ignores a core pulse while busy;
  // the sweep under way already clears every word
  // Only the full reset starts the wipe
  assign wipe_start = core_reset_out;
  srctl_ram_wipe #(
    .DEPTH(DEPTH)
  ) u_wipe (
    .clk_in(clk_in),
    .rst_n_in(rst_n),
    .start_in(wipe_start),
    .busy_out(wipe_busy),
    .addr_out(wipe_addr)
  );
  // Registered wipe strobe and address
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      ram_wipe_out <= 1'b0;
      ram_addr_out <= '0;
    end else begin
      ram_wipe_out <= wipe_busy;
      ram_addr_out <= wipe_addr;
    end
  end
  // Length of the current wipe strobe, read only by the checks below
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      wipe_run <= '0;
    end else if (ram_wipe_out) begin
      wipe_run <= wipe_run + 1'b1;
    end else begin
      wipe_run <= '0;
    end
  end
  // Idle wiper starts two cycles after the core pulse
  a_wipe_start: assert property (@(posedge clk_in) disable iff (!rst_n)
    core_reset_out && !wipe_busy
    |=> ##1 ram_wipe_out)
    else $error("wipe not started");
  // Every wipe traces back to a core pulse
  a_no_wipe: assert property (@(posedge clk_in) disable iff (!rst_n)
    $rose(ram_wipe_out)
    |-> $past(core_reset_out, 2))
    else $error("wipe without core reset");
  // Register-only reset leaves the wiper idle
  a_reg_idle_ram: assert property (@(posedge clk_in) disable iff (!rst_n)
    regs_reset_out && !core_reset_out && !wipe_busy
    |=> !wipe_busy)
    else $error("register reset touched ram");
  // Sweep opens at word zero
  a_wipe_begin_zero: assert property (@(posedge clk_in) disable iff (!rst_n)
    $rose(ram_wipe_out)
    |-> ram_addr_out == '0)
    else $error("wipe did not start at zero");
  // One word per cycle, no gaps
  a_wipe_step: assert property (@(posedge clk_in) disable iff (!rst_n)
    ram_wipe_out && $past(ram_wipe_out)
    |-> ram_addr_out == $past(ram_addr_out) + 1'b1)
    else $error("wipe address skipped");
  // Sweep closes on the last word
  a_wipe_end_top: assert property (@(posedge clk_in) disable iff (!rst_n)
    $fell(ram_wipe_out)
    |-> $past(ram_addr_out) == LAST_ADDR)
    else $error("wipe ended early");
  // Exactly one strobe per word
  a_wipe_length: assert property (@(posedge clk_in) disable iff (!rst_n)
    $fell(ram_wipe_out)
    |-> wipe_run == RUN_FULL)
    else $error("wipe length wrong");
  // A core write during a sweep must not stretch it
  a_wipe_bound: assert property (@(posedge clk_in) disable iff (!rst_n)
    ram_wipe_out
    |-> wipe_run < RUN_FULL)
    else $error("wipe ran too long");
  // Address parks at zero between sweeps
  a_wipe_addr_idle: assert property (@(posedge clk_in) disable iff (!rst_n)
    !ram_wipe_out
    |-> ram_addr_out == '0)
    else $error("wipe address not parked");
  // Every sweep finishes in bounded time
  a_wipe_ends: assert property (@(posedge clk_in) disable iff (!rst_n)
    $rose(ram_wipe_out)
    |-> ##[1:WIPE_SPAN] !ram_wipe_out)
    else $error("wipe did not finish");
  // Read data: soft reset register always zero
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      rdata_out <= `SRCTL_SOFT_RESET_RST;
    end else if (rd_en_in) begin
      rdata_out <= `SRCTL_SOFT_RESET_RST;
    end
  end
  // Write-clear bits and reserved bits never read back set
  a_read_zero: assert property (@(posedge clk_in) disable iff (!rst_n)
    1'b1
    |-> rdata_out == `SRCTL_SOFT_RESET_RST)
    else $error("reads not zero");
  // A read answers zero on the next cycle
  a_read_after: assert property (@(posedge clk_in) disable iff (!rst_n)
    rd_en_in
    |=> rdata_out == `SRCTL_SOFT_RESET_RST)
    else $error("read answer not zero");
endmodule

//--- srctl_host.sv
`timescale 1ns/100ps
module srctl_host (
  input wire logic clk_in,
  output logic we_out = 1'b0,
  output logic re_out = 1'b0,
  output logic [7:0] a_out = 8'h00,
  output logic [7:0] d_out = 8'h00
);
  // One-cycle strobe on the soft-reset offset only; reserved offsets left alone
  task automatic access(input logic wr, input logic [7:0] d);
    @(negedge clk_in);
    we_out <= wr;
    re_out <= !wr;
    a_out <= 8'h01;
    d_out <= d;
    @(negedge clk_in);
    we_out <= 1'b0;
    re_out <= 1'b0;
    a_out <= 8'hfe; // Released bus, no stale offset
    d_out <= ~d;
  endtask
endmodule

//--- srctl_test.sv
`timescale 1ns/100ps
module srctl_test;
  localparam int DEPTH = 4;
  localparam logic [39:0] CV = 40'hff_ee_00_01_10;
  logic clk = 1'b0, rst_n = 1'b0;
  logic we, re, core, regs, wipe;
  logic [7:0] a, d, rd;
  logic [1:0] wa;
  int n_fail = 0;
  int n_tests = 0;
  int nc, nr, nw, seed = 32'h8edc;
  initial forever #12.5 clk = ~clk;
  srctl_host u_host (.clk_in(clk), .we_out(we), .re_out(re), .a_out(a), .d_out(d));
  srctl_top #(.DEPTH(DEPTH)) u_dut (.clk_in(clk), .arst_n_in(rst_n), .wr_en_in(we),
    .rd_en_in(re), .addr_in(a), .wdata_in(d), .rdata_out(rd), .core_reset_out(core),
    .regs_reset_out(regs), .ram_wipe_out(wipe), .ram_addr_out(wa));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Expected pulse count for one action bit
  function automatic logic [7:0] exp_pulse(input logic b);
    return {7'h00, b};
  endfunction
  // Expected wipe strobes for one written byte
  function automatic logic [7:0] exp_wipe(input logic [7:0] v);
    return v[4] ? 8'(DEPTH) : 8'h00;
  endfunction
  // Tally pulses; wipe address must step up from zero
  always @(posedge clk) begin
    nc += (core === 1'b1);
    nr += (regs === 1'b1);
    if (wipe === 1'b1) begin
      chk({6'h00, wa}, nw[7:0]);
      nw++;
    end
  end
  // Window of 12 cycles covers pulse latency plus a full wipe
  task automatic op(input logic [7:0] v);
    {nc, nr, nw} = '0;
    u_host.access(1'b1, v);
    repeat (12) @(negedge clk);
    chk(nc[7:0], exp_pulse(v[4]));
    chk(nr[7:0], exp_pulse(v[4] | v[0]));
    chk(nw[7:0], exp_wipe(v));
    u_host.access(1'b0, 8'h00);
    @(negedge clk);
    chk(rd, 8'h00);
  endtask
  task automatic finish_test;
    $display("tests %0d fails %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // Corner values first, then random bytes
  initial begin
    repeat (12) @(negedge clk);
    rst_n = 1'b1;
    repeat (3) @(negedge clk);
    chk(rd, 8'h00);
    for (int i = 0; i < 25; i++) op(i < 5 ? CV[i*8 +: 8] : 8'($random(seed)));
    // Back to back core writes: the second lands mid-wipe and is ignored
    {nc, nr, nw} = '0;
    u_host.access(1'b1, 8'h10);
    u_host.access(1'b1, 8'h11);
    repeat (12) @(negedge clk);
    chk(nc[7:0], 8'h02);
    chk(nr[7:0], 8'h02);
    chk(nw[7:0], exp_wipe(8'h10));
    finish_test();
  end
  // Hang guard
  initial begin
    #50000 n_fail++;
    finish_test();
  end
endmodule
